// ===== hdl/cod_decode.v
// Opcode decode and execute sequencer with APB control registers
//
// Implementation choices: register access over APB and the address map.
`include "cod_defines.vh"

module cod_decode #(
    parameter PC_W = 16,
    parameter AW   = 8
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [7:0]      paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output wire            pready,
    output wire            pslverr,
    output wire [PC_W-1:0] prog_addr,
    input  wire [7:0]      prog_data,
    input  wire            irq_req,
    input  wire            dma_req,
    output wire            irq_pass,
    output wire            dma_pass,
    output wire [7:0]      flags,
    output reg             alu_we,
    output reg  [AW-1:0]   alu_addr,
    output reg  [7:0]      alu_data
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_FETCH = 3'b010;
    localparam ST_EXEC  = 3'b100;

    reg  [2:0]      state_reg;
    reg  [2:0]      fcnt_reg;
    reg  [2:0]      step_reg;
    reg  [7:0]      op_reg;
    reg  [7:0]      b1_reg;
    reg  [7:0]      b2_reg;
    reg  [7:0]      b3_reg;
    reg  [PC_W-1:0] pc_reg;
    reg  [7:0]      flag_reg;
    reg  [1:0]      atm_reg;
    reg  [AW-1:0]   da_reg;
    reg  [AW-1:0]   sa_reg;
    reg             run_reg;
    reg             ill_reg;

    // Fetch length per opcode
    function [2:0] flen;
        input [7:0] op;
        begin
            if ((op[7:4] == `COD_HI_ADD || op[7:4] == `COD_HI_ADC ||
                 op[7:4] == `COD_HI_AND) && op[3:0] >= 4'h2 &&
                op[3:0] <= 4'h9) begin
                if (op[3:0] <= 4'h3)
                    flen = `COD_FE_2;
                else if (op[3:0] <= 4'h7)
                    flen = `COD_FE_3;
                else
                    flen = `COD_FE_4;
            end else if (op == `COD_OP_BTJ_R || op == `COD_OP_BTJ_IR)
                flen = `COD_FE_3;
            else if (op == `COD_OP_BITW || op[3:0] == `COD_LO_COUNT_DOWN_LOOP ||
                     op == `COD_OP_RLC_R || op == `COD_OP_RLC_IR ||
                     op == `COD_OP_RRC_R || op == `COD_OP_RRC_IR)
                flen = `COD_FE_2;
            else
                flen = `COD_FE_1;
        end
    endfunction

    // Execute length per opcode
    function [2:0] elen;
        input [7:0] op;
        begin
            if ((op[7:4] == `COD_HI_ADD || op[7:4] == `COD_HI_ADC ||
                 op[7:4] == `COD_HI_AND) && op[3:0] >= 4'h2 &&
                op[3:0] <= 4'h9) begin
                if (op[3:0] == 4'h3 || op[3:0] == 4'h5 || op[3:0] == 4'h7)
                    elen = `COD_EX_4;
                else
                    elen = `COD_EX_3;
            end else if (op == `COD_OP_BTJ_IR)
                elen = `COD_EX_4;
            else if (op == `COD_OP_BTJ_R || op[3:0] == `COD_LO_COUNT_DOWN_LOOP ||
                     op == `COD_OP_RLC_IR || op == `COD_OP_RRC_IR)
                elen = `COD_EX_3;
            else if (op == `COD_OP_ATM || op == `COD_OP_BITW ||
                     op == `COD_OP_RLC_R || op == `COD_OP_RRC_R)
                elen = `COD_EX_2;
            else
                elen = `COD_EX_1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode of the latched opcode
    wire [3:0] hi     = op_reg[7:4];
    wire [3:0] lo     = op_reg[3:0];
    wire       is_alu = (hi == `COD_HI_ADD || hi == `COD_HI_ADC ||
                         hi == `COD_HI_AND) && lo >= 4'h2 && lo <= 4'h9;
    wire       is_adc = is_alu && hi == `COD_HI_ADC;
    wire       is_and = is_alu && hi == `COD_HI_AND;
    wire       is_btj = op_reg == `COD_OP_BTJ_R || op_reg == `COD_OP_BTJ_IR;
    wire       is_djz = lo == `COD_LO_COUNT_DOWN_LOOP;
    wire       is_bit = op_reg == `COD_OP_BITW;
    wire       is_rlc = op_reg == `COD_OP_RLC_R || op_reg == `COD_OP_RLC_IR;
    wire       is_rrc = op_reg == `COD_OP_RRC_R || op_reg == `COD_OP_RRC_IR;
    wire       is_atm = op_reg == `COD_OP_ATM;
    wire       is_ill = !(is_alu || is_btj || is_djz || is_bit ||
                          is_rlc || is_rrc || is_atm);
    wire [2:0] ex_len = elen(op_reg);
    wire       last   = state_reg == ST_EXEC && step_reg == ex_len - 3'd1;

    // Current opcode is the program byte during the first fetch cycle
    wire [7:0] cur_op = (fcnt_reg == 3'd0) ? prog_data : op_reg;
    wire [2:0] fe_len = flen(cur_op);

    // Operand addresses and indirection per addressing form
    reg [AW-1:0] dst_base;
    reg [AW-1:0] src_base;
    reg          ind_d;
    reg          ind_s;
    reg          use_imm;
    reg [7:0]    imm;
    always @* begin
        dst_base = {`COD_WRK_BANK, b1_reg[3:0]};
        src_base = {`COD_WRK_BANK, b1_reg[3:0]};
        ind_d    = 1'b0;
        ind_s    = 1'b0;
        use_imm  = 1'b0;
        imm      = b2_reg;
        if (is_alu) begin
            case (lo)
                4'h2: dst_base = {`COD_WRK_BANK, b1_reg[7:4]};
                4'h3: begin
                    dst_base = {`COD_WRK_BANK, b1_reg[7:4]};
                    ind_s    = 1'b1;
                end
                4'h4: begin
                    dst_base = b2_reg;
                    src_base = b1_reg;
                end
                4'h5: begin
                    dst_base = b2_reg;
                    src_base = b1_reg;
                    ind_s    = 1'b1;
                end
                4'h6: begin
                    dst_base = b1_reg;
                    use_imm  = 1'b1;
                end
                4'h7: begin
                    dst_base = b1_reg;
                    ind_d    = 1'b1;
                    use_imm  = 1'b1;
                end
                4'h8: begin
                    dst_base = b3_reg;
                    src_base = {b1_reg[3:0], b2_reg[7:4]};
                end
                default: begin
                    dst_base = b3_reg;
                    use_imm  = 1'b1;
                    imm      = b1_reg;
                end
            endcase
        end else if (is_djz) begin
            dst_base = {`COD_WRK_BANK, hi};
        end else if (is_rlc || is_rrc) begin
            dst_base = b1_reg;
            ind_d    = op_reg[0];
        end else if (is_btj) begin
            ind_d    = op_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and pointer resolution
    wire [7:0]    rd_a;
    wire [7:0]    rd_b;
    wire [AW-1:0] ra_a = !ind_d ? dst_base :
                         (step_reg == 3'd0) ? dst_base :
                         (step_reg == 3'd1) ? rd_a : da_reg;
    wire [AW-1:0] ra_b = !ind_s ? src_base :
                         (step_reg == 3'd0) ? src_base :
                         (step_reg == 3'd1) ? rd_b : sa_reg;
    wire [AW-1:0] wr_a = ind_d ? da_reg : dst_base;
    reg           res_we;
    reg  [7:0]    res;

    cod_regfile #(.AW(AW), .DW(8)) u_rf (
        .clk     (pclk),
        .rstn    (presetn),
        .we      (last && res_we),
        .waddr   (wr_a),
        .wdata   (res),
        .raddr_a (ra_a),
        .rdata_a (rd_a),
        .raddr_b (ra_b),
        .rdata_b (rd_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Result, flags and branch at the final execute cycle
    wire [7:0] a    = rd_a;
    wire [7:0] b    = use_imm ? imm : rd_b;
    wire       cin  = is_adc & flag_reg[`COD_FL_C];
    wire [8:0] sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    wire [4:0] hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    reg  [7:0] nfl;
    reg        take;
    reg  [7:0] disp;
    always @* begin
        res    = a;
        res_we = 1'b0;
        nfl    = flag_reg;
        take   = 1'b0;
        disp   = b1_reg;
        if (is_and) begin
            res    = a & b;
            res_we = 1'b1;
            nfl[`COD_FL_Z] = (res == 8'h00);
            nfl[`COD_FL_S] = res[7];
            nfl[`COD_FL_V] = 1'b0;
        end else if (is_alu) begin
            res    = sum[7:0];
            res_we = 1'b1;
            nfl[`COD_FL_C] = sum[8];
            nfl[`COD_FL_Z] = (res == 8'h00);
            nfl[`COD_FL_S] = res[7];
            nfl[`COD_FL_V] = (a[7] == b[7]) && (res[7] != a[7]);
            nfl[`COD_FL_D] = 1'b0;
            nfl[`COD_FL_H] = hsum[4];
        end else if (is_rlc || is_rrc) begin
            res_we = 1'b1;
            if (is_rlc) begin
                res = {a[6:0], flag_reg[`COD_FL_C]};
                nfl[`COD_FL_C] = a[7];
            end else begin
                res = {flag_reg[`COD_FL_C], a[7:1]};
                nfl[`COD_FL_C] = a[0];
            end
            nfl[`COD_FL_Z] = (res == 8'h00);
            nfl[`COD_FL_S] = res[7];
            nfl[`COD_FL_V] = res[7] ^ a[7];
        end else if (is_djz) begin
            res    = a - 8'h01;
            res_we = 1'b1;
            take   = (res != 8'h00);
        end else if (is_bit) begin
            res    = a;
            res[b1_reg[6:4]] = b1_reg[7];
            res_we = 1'b1;
        end else if (is_btj) begin
            take   = (a[b1_reg[6:4]] == b1_reg[7]);
            disp   = b2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB access decode
    wire apb_acc = psel & penable;
    wire apb_wr  = apb_acc & pwrite;
    wire mapped  = paddr == `COD_CTRL_OFF || paddr == `COD_STAT_OFF ||
                   paddr == `COD_FLAG_OFF || paddr == `COD_PC_OFF ||
                   paddr == `COD_OPC_OFF;
    wire idle    = state_reg == ST_IDLE;
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~mapped;

    // Read data mux
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `COD_CTRL_OFF: rd_mux[`COD_CTRL_RUN] = run_reg;
            `COD_STAT_OFF: begin
                rd_mux[`COD_STAT_BUSY] = ~idle;
                rd_mux[`COD_STAT_ILL]  = ill_reg;
                rd_mux[`COD_STAT_ATM+1:`COD_STAT_ATM] = atm_reg;
            end
            `COD_FLAG_OFF: rd_mux[7:0] = flag_reg;
            `COD_PC_OFF:   rd_mux[PC_W-1:0] = pc_reg;
            `COD_OPC_OFF:  rd_mux[7:0] = op_reg;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Read word captured in setup, stands through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // Run control and illegal-opcode sticky bit, set beats clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= `COD_CTRL_RST;
            ill_reg <= 1'b0;
        end else begin
            if (apb_wr && paddr == `COD_CTRL_OFF)
                run_reg <= pwdata[`COD_CTRL_RUN];
            if (last && is_ill)
                ill_reg <= 1'b1;
            else if (apb_wr && paddr == `COD_STAT_OFF &&
                     pwdata[`COD_STAT_ILL])
                ill_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch and execute sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            fcnt_reg  <= 3'd0;
            step_reg  <= 3'd0;
            op_reg    <= 8'h00;
            b1_reg    <= 8'h00;
            b2_reg    <= 8'h00;
            b3_reg    <= 8'h00;
            pc_reg    <= `COD_PC_RST;
            flag_reg  <= `COD_FLAG_RST;
            atm_reg   <= 2'd0;
            da_reg    <= {AW{1'b0}};
            sa_reg    <= {AW{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (apb_wr && paddr == `COD_PC_OFF)
                        pc_reg <= pwdata[PC_W-1:0];
                    if (apb_wr && paddr == `COD_FLAG_OFF)
                        flag_reg <= pwdata[7:0];
                    if (run_reg)
                        state_reg <= ST_FETCH;
                end
                ST_FETCH: begin
                    // One program byte per fetch cycle
                    pc_reg <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
                    case (fcnt_reg)
                        3'd0:    op_reg <= prog_data;
                        3'd1:    b1_reg <= prog_data;
                        3'd2:    b2_reg <= prog_data;
                        default: b3_reg <= prog_data;
                    endcase
                    if (fcnt_reg + 3'd1 == fe_len) begin
                        fcnt_reg  <= 3'd0;
                        step_reg  <= 3'd0;
                        state_reg <= ST_EXEC;
                    end else begin
                        fcnt_reg <= fcnt_reg + 3'd1;
                    end
                end
                ST_EXEC: begin
                    // Latch resolved pointers of indirect forms
                    if (step_reg == 3'd1) begin
                        da_reg <= rd_a;
                        sa_reg <= rd_b;
                    end
                    if (last) begin
                        flag_reg <= nfl;
                        if (take)
                            pc_reg <= pc_reg + {{(PC_W-8){disp[7]}}, disp};
                        if (is_atm)
                            atm_reg <= `COD_ATM_SPAN;
                        else if (atm_reg != 2'd0)
                            atm_reg <= atm_reg - 2'd1;
                        step_reg  <= 3'd0;
                        state_reg <= run_reg ? ST_FETCH : ST_IDLE;
                    end else begin
                        step_reg <= step_reg + 3'd1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Write-back mirror for observation of the result path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_we   <= 1'b0;
            alu_addr <= {AW{1'b0}};
            alu_data <= 8'h00;
        end else begin
            alu_we <= last && res_we;
            if (last && res_we) begin
                alu_addr <= wr_a;
                alu_data <= res;
            end
        end
    end

    // Request gating while an atomic window is open
    assign irq_pass  = irq_req & (atm_reg == 2'd0);
    assign dma_pass  = dma_req & (atm_reg == 2'd0);
    assign prog_addr = pc_reg;
    assign flags     = flag_reg;

endmodule

// ===== hdl/cod_defines.vh
// Constants for the opcode decode and execute block
`ifndef COD_DEFINES_VH
`define COD_DEFINES_VH

// APB register byte offsets
`define COD_CTRL_OFF    8'h00
`define COD_STAT_OFF    8'h04
`define COD_FLAG_OFF    8'h08
`define COD_PC_OFF      8'h0c
`define COD_OPC_OFF     8'h10

// Field positions
`define COD_CTRL_RUN    0
`define COD_STAT_BUSY   0
`define COD_STAT_ILL    1
`define COD_STAT_ATM    4
`define COD_FL_C        7
`define COD_FL_Z        6
`define COD_FL_S        5
`define COD_FL_V        4
`define COD_FL_D        3
`define COD_FL_H        2

// Reset values
`define COD_FLAG_RST    8'h00
`define COD_PC_RST      16'h0000
`define COD_CTRL_RST    1'b0

// Opcodes and opcode families
`define COD_OP_ATM      8'h2f
`define COD_OP_BITW     8'he2
`define COD_OP_BTJ_R    8'hf6
`define COD_OP_BTJ_IR   8'hf7
`define COD_OP_RLC_R    8'h10
`define COD_OP_RLC_IR   8'h11
`define COD_OP_RRC_R    8'hc0
`define COD_OP_RRC_IR   8'hc1
`define COD_HI_ADD      4'h0
`define COD_HI_ADC      4'h1
`define COD_HI_AND      4'h5
`define COD_LO_COUNT_DOWN_LOOP     4'ha
`define COD_WRK_BANK    4'he

// Timing counts: atomic span in executed instructions, fetch and execute lengths in clock cycles
`define COD_ATM_SPAN    2'd3
`define COD_FE_1        3'd1
`define COD_FE_2        3'd2
`define COD_FE_3        3'd3
`define COD_FE_4        3'd4
`define COD_EX_1        3'd1
`define COD_EX_2        3'd2
`define COD_EX_3        3'd3
`define COD_EX_4        3'd4

`endif

// ===== hdl/cod_regfile.v
// Register file with two registered read ports and one write port
module cod_regfile #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr_a,
    output reg  [DW-1:0] rdata_a,
    input  wire [AW-1:0] raddr_b,
    output reg  [DW-1:0] rdata_b
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Storage write
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read data, one cycle after the address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_a <= {DW{1'b0}};
            rdata_b <= {DW{1'b0}};
        end else begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end

endmodule

// ===== tb/cod_decode_sva.sv
// Port assertions for the opcode decode block
module cod_decode_sva #(
    parameter PC_W = 16,
    parameter AW   = 8
) (
    input logic            pclk,
    input logic            presetn,
    input logic            psel,
    input logic            penable,
    input logic            pwrite,
    input logic [7:0]      paddr,
    input logic [31:0]     pwdata,
    input logic [31:0]     prdata,
    input logic            pready,
    input logic            pslverr,
    input logic [PC_W-1:0] prog_addr,
    input logic [7:0]      prog_data,
    input logic            irq_req,
    input logic            dma_req,
    input logic            irq_pass,
    input logic            dma_pass,
    input logic [7:0]      flags,
    input logic            alu_we,
    input logic [AW-1:0]   alu_addr,
    input logic [7:0]      alu_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////
    // Access phase and decoded map
    assign acc    = psel && penable;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= 8'h10);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    property p_err_unmap;
        acc && !mapped |-> pslverr;
    endproperty
    a_err_unmap: assert property (p_err_unmap)
        else $error("no error on unmapped access");
    property p_err_map;
        acc && mapped |-> !pslverr;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error on mapped access");
    property p_err_only;
        pslverr |-> acc;
    endproperty
    a_err_only: assert property (p_err_only)
        else $error("error outside access phase");
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state inserted");
    property p_irq_gate;
        irq_pass |-> irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt passed without request");
    property p_dma_gate;
        dma_pass |-> dma_req;
    endproperty
    a_dma_gate: assert property (p_dma_gate)
        else $error("dma passed without request");
    property p_pass_pair;
        irq_req && dma_req |-> irq_pass == dma_pass;
    endproperty
    a_pass_pair: assert property (p_pass_pair)
        else $error("interrupt and dma gating differ");
    property p_atm_span;
        $fell(irq_pass) && irq_req && $past(irq_req) |-> (!irq_pass) [*6];
    endproperty
    a_atm_span: assert property (p_atm_span)
        else $error("atomic window closed too early");
    property p_we_pulse;
        alu_we |=> !alu_we;
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("register writes too close");
    property p_alu_hold;
        !alu_we |-> $stable(alu_addr) && $stable(alu_data);
    endproperty
    a_alu_hold: assert property (p_alu_hold)
        else $error("write address or data moved without a write");
endmodule

// ===== tb/cod_prog_mem.sv
// Program memory model with a load port for the bench
module cod_prog_mem #(
    parameter PC_W = 16
) (
    input  logic            pclk,
    input  logic            ld_en,
    input  logic [7:0]      ld_addr,
    input  logic [7:0]      ld_data,
    input  logic [PC_W-1:0] prog_addr,
    output logic [7:0]      prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];

    // Unloaded bytes read as an undefined opcode
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hff;
    end
    always @(posedge pclk) begin
        if (ld_en) mem[ld_addr] <= ld_data;
    end
    // Same-cycle read; outside the loaded page a changing pattern
    assign prog_data = (prog_addr[PC_W-1:8] == '0) ? mem[prog_addr[7:0]]
                                                   : ~prog_addr[7:0];
endmodule

// ===== tb/cod_decode_tb.sv
// Self-checking bench for the opcode decode block
module cod_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam PC_W = 16;
    localparam AW   = 8;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]      paddr, prog_data, flags, alu_data, ld_addr, ld_data;
    logic [31:0]     pwdata, prdata;
    logic [PC_W-1:0] prog_addr;
    logic [AW-1:0]   alu_addr;
    logic            irq_req, dma_req, irq_pass, dma_pass, alu_we, ld_en;
    int              fail_count, compares, idx, cyc, last;
    logic [7:0]      prog [0:26] = '{8'h56, 8'he0, 8'h00, 8'h06, 8'he0,
        8'h7f, 8'h06, 8'he0, 8'h01, 8'h16, 8'he0, 8'h80, 8'h2f, 8'h10,
        8'he0, 8'hc0, 8'he0, 8'h52, 8'h00, 8'he2, 8'hf0, 8'hf6, 8'h70,
        8'hfd, 8'hf6, 8'hf0, 8'hfd};
    logic [7:0]      e_data [0:7] = '{8'h00, 8'h7f, 8'h80, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h80};
    logic [7:0]      e_flag [0:7] = '{8'h40, 8'h00, 8'h34, 8'hd0, 8'h00,
        8'hc0, 8'hc0, 8'hc0};
    logic            e_pass [0:7] = '{1, 1, 1, 1, 0, 0, 1, 1};
    int              e_gap [0:7] = '{0, 6, 6, 6, 7, 4, 5, 4};
    logic [7:0]      prog_b [0:11] = '{8'h56, 8'he1, 8'h00, 8'h06,
        8'he1, 8'h02, 8'h1a, 8'hfe, 8'hff, 8'hf6, 8'hf0, 8'hfd};

    cod_decode #(.PC_W(PC_W), .AW(AW)) cod_decode_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
        .irq_req(irq_req), .dma_req(dma_req), .irq_pass(irq_pass),
        .dma_pass(dma_pass), .flags(flags), .alu_we(alu_we),
        .alu_addr(alu_addr), .alu_data(alu_data));
    cod_prog_mem #(.PC_W(PC_W)) cod_prog_mem_i (.pclk(pclk), .ld_en(ld_en),
        .ld_addr(ld_addr), .ld_data(ld_data), .prog_addr(prog_addr),
        .prog_data(prog_data));

    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, waits on pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic test_done;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Each of the first eight register writes against the expected sequence
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (presetn === 1'b1 && alu_we === 1'b1 && idx < 8) begin
            chk(32'(alu_addr), 32'he0);
            chk(32'(alu_data), 32'(e_data[idx]));
            chk(32'(flags), 32'(e_flag[idx]));
            chk(32'(irq_pass), 32'(e_pass[idx]));
            chk(32'(dma_pass), 32'(e_pass[idx]));
            if (idx > 0) chk(32'(cyc - last), 32'(e_gap[idx]));
            idx <= idx + 1;
            last <= cyc;
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("MISMATCH t=%0t timeout", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic        er;
        int          n;
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, ld_en} = '0;
        {paddr, ld_addr, ld_data, pwdata} = '0;
        {irq_req, dma_req} = 2'b11;
        {fail_count, compares, idx, cyc, last} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 27; i++) begin
            ld_en <= 1'b1;
            ld_addr <= 8'(i);
            ld_data <= prog[i];
            @(posedge pclk);
        end
        ld_en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, er);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(32'(irq_pass), 32'h1);
        $display("test reset done");
        apb(1'b1, 8'h00, 32'h1, rd, er);
        n = 0;
        while (idx < 8 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        repeat (20) @(posedge pclk);
        chk(32'(idx), 32'd8);
        apb(1'b1, 8'h00, 32'h0, rd, er);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0, rd, er);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk(rd, 32'h18);
        apb(1'b0, 8'h10, 32'h0, rd, er);
        chk(rd, 32'hf6);
        $display("test program done");
        apb(1'b1, 8'h08, 32'ha5, rd, er);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk(rd, 32'ha5);
        chk(32'(flags), 32'ha5);
        apb(1'b1, 8'h18, 32'h1, rd, er);
        chk({31'h0, er}, 32'h1);
        $display("test registers done");
        // Count-down loop, illegal opcode, then a bit-test self loop
        for (int i = 0; i < 12; i++) begin
            ld_en <= 1'b1;
            ld_addr <= 8'(32 + i);
            ld_data <= prog_b[i];
            @(posedge pclk);
        end
        ld_en <= 1'b0;
        apb(1'b1, 8'h0c, 32'h20, rd, er);
        apb(1'b1, 8'h00, 32'h1, rd, er);
        repeat (100) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h0, rd, er);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0, rd, er);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        chk(rd, 32'h2);
        chk(32'(alu_addr), 32'he1);
        chk(32'(alu_data), 32'h0);
        chk(32'(flags), 32'h1);
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk(rd, 32'h29);
        apb(1'b1, 8'h04, 32'h2, rd, er);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd, 32'h0);
        {irq_req, dma_req} <= 2'b00;
        @(posedge pclk);
        chk({30'h0, irq_pass, dma_pass}, 32'h0);
        {irq_req, dma_req} <= 2'b11;
        $display("test loop done");
        test_done();
    end
endmodule

bind cod_decode cod_decode_sva #(.PC_W(PC_W), .AW(AW)) sva_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
    .irq_req(irq_req), .dma_req(dma_req), .irq_pass(irq_pass),
    .dma_pass(dma_pass), .flags(flags), .alu_we(alu_we),
    .alu_addr(alu_addr), .alu_data(alu_data));
